//--- common/apsb_pkg.sv
// Package for the async/page pseudo-static memory bus controller
// Assumes a 250 MHz system clock; all timing counts derive from it
package apsb_pkg;

   // ---------------------------------------------------------------
   // Clock and timing
   // ---------------------------------------------------------------
   localparam int CLK_MHZ         = 250;
   localparam int INIT_US         = 150;                  // Self-init time
   localparam int INIT_CYC        = INIT_US * CLK_MHZ;    // 37500 cycles
   localparam int SLEEP_ENTRY_US  = 10;                   // Sleep pin low time
   localparam int SLEEP_CYC       = SLEEP_ENTRY_US * CLK_MHZ;
   localparam int ACC_NS          = 70;                   // Random access
   localparam int ACC_CYC         = (ACC_NS * CLK_MHZ + 999) / 1000;
   localparam int PAGE_NS         = 20;                   // Intrapage access
   localparam int PAGE_CYC        = (PAGE_NS * CLK_MHZ + 999) / 1000;
   localparam int WP_NS           = 70;                   // Write strobe width
   localparam int WP_CYC          = (WP_NS * CLK_MHZ + 999) / 1000;

   // ---------------------------------------------------------------
   // Device pin widths and configuration word
   // ---------------------------------------------------------------
   localparam int          ADDR_W      = 22;
   localparam int          DATA_W      = 16;
   localparam logic [21:0] CFG_RESET   = 22'h000070;  // Power-up config value
   localparam int          CFG_SLEEP_B = 4;           // 0 deep, 1 limited refresh
   localparam int          CFG_PAGE_B  = 7;           // Page read enable
   localparam int          PAGE_LSB_W  = 4;           // Word select in page

   // ---------------------------------------------------------------
   // Controller registers (byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] REG_CTRL   = 8'h00;  // [1:0] op, [2] go, [5:4] lanes
   localparam logic [7:0] REG_ADDR   = 8'h04;  // Word address or config value
   localparam logic [7:0] REG_WDATA  = 8'h08;
   localparam logic [7:0] REG_RDATA  = 8'h0c;
   localparam logic [7:0] REG_STATUS = 8'h10;  // [0] busy,[1] ready,[2] page,[3] sleep
   localparam logic [7:0] REG_SLEEP  = 8'h14;  // [0] request sleep

   localparam int CTRL_GO_B = 2;

   // Commands
   typedef enum logic [1:0] {
      APSB_OP_READ  = 2'b00,
      APSB_OP_WRITE = 2'b01,
      APSB_OP_CFG   = 2'b10,
      APSB_OP_NONE  = 2'b11
   } apsb_op_t;

   // Controller states
   typedef enum logic [3:0] {
      APSB_S_INIT   = 4'b0000,
      APSB_S_IDLE   = 4'b0001,
      APSB_S_RD     = 4'b0010,
      APSB_S_WR     = 4'b0011,
      APSB_S_WREND  = 4'b0100,
      APSB_S_CFGZ   = 4'b0101,
      APSB_S_CFGW   = 4'b0110,
      APSB_S_CFGEND = 4'b0111,
      APSB_S_SLEEP  = 4'b1000
   } apsb_state_t;

endpackage : apsb_pkg

//--- common/apsb_cmd_if.sv
// Interface between the bus slave and the pin sequencer
// Assumes one clock; go is a one-cycle pulse, done likewise
`timescale 1ns/1ps
interface apsb_cmd_if;
   logic        go;
   logic [1:0]  op;
   logic [1:0]  lanesN;
   logic [21:0] addr;
   logic [15:0] wdata;
   logic        sleepReq;
   logic        done;
   logic [15:0] rdata;
   logic        busy;
   logic        ready;
   logic        pageOn;
   logic        asleep;

   modport master (output go, op, lanesN, addr, wdata, sleepReq,
                   input done, rdata, busy, ready, pageOn, asleep);
   modport seq    (input go, op, lanesN, addr, wdata, sleepReq,
                   output done, rdata, busy, ready, pageOn, asleep);
endinterface : apsb_cmd_if

//--- logic/apsb_ahb_regs.sv
// AHB-Lite slave holding the controller's own command and status words
// Assumes single word transfers; always zero wait states, OKAY response
`timescale 1ns/1ps
module apsb_ahb_regs (
   input  wire logic        sys_clk,
   input  wire logic        rst_n,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   apsb_cmd_if.master       cmd
);
   import apsb_pkg::*;

   logic [7:0]  aAddr_q, aAddr_d;
   logic        aWr_q, aWr_d;
   logic [5:0]  ctrl_q, ctrl_d;
   logic [21:0] addr_q, addr_d;
   logic [15:0] wdat_q, wdat_d;
   logic [15:0] rdat_q, rdat_d;
   logic        sleep_q, sleep_d;
   logic        go_q, go_d;
   logic [31:0] rd_q, rd_d;

   // ---------------------------------------------------------------
   // Address phase capture, write data phase, read mux
   // ---------------------------------------------------------------
   always_comb begin
      logic take;
      take    = hsel && hready && htrans[1];
      aAddr_d = take ? haddr[7:0] : aAddr_q;
      aWr_d   = take && hwrite;
      ctrl_d  = ctrl_q;
      addr_d  = addr_q;
      wdat_d  = wdat_q;
      sleep_d = sleep_q;
      go_d    = 1'b0;
      rdat_d  = cmd.done ? cmd.rdata : rdat_q;
      rd_d    = rd_q;
      if (aWr_q) begin
         case (aAddr_q)
            REG_CTRL: begin
               ctrl_d = hwdata[5:0];
               go_d   = hwdata[CTRL_GO_B] && !cmd.busy;  // Ignored while busy
            end
            REG_ADDR:  addr_d  = hwdata[21:0];
            REG_WDATA: wdat_d  = hwdata[15:0];
            REG_SLEEP: sleep_d = hwdata[0];
            default:   ;
         endcase
      end
      if (take && !hwrite) begin
         case (haddr[7:0])
            REG_CTRL:   rd_d = {26'h0000000, ctrl_q};
            REG_ADDR:   rd_d = {10'h000, addr_q};
            REG_WDATA:  rd_d = {16'h0000, wdat_q};
            REG_RDATA:  rd_d = {16'h0000, rdat_d};
            REG_STATUS: rd_d = {28'h0000000, cmd.asleep, cmd.pageOn, cmd.ready, cmd.busy};
            REG_SLEEP:  rd_d = {31'h00000000, sleep_q};
            default:    rd_d = 32'h00000000;
         endcase
      end
   end

   // Register all bus-side state
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         aAddr_q <= 8'h00;
         aWr_q   <= 1'b0;
         ctrl_q  <= 6'h33;
         addr_q  <= 22'h000000;
         wdat_q  <= 16'h0000;
         rdat_q  <= 16'h0000;
         sleep_q <= 1'b0;
         go_q    <= 1'b0;
         rd_q    <= 32'h00000000;
      end else begin
         aAddr_q <= aAddr_d;
         aWr_q   <= aWr_d;
         ctrl_q  <= ctrl_d;
         addr_q  <= addr_d;
         wdat_q  <= wdat_d;
         rdat_q  <= rdat_d;
         sleep_q <= sleep_d;
         go_q    <= go_d;
         rd_q    <= rd_d;
      end
   end

   assign hrdata       = rd_q;
   assign hreadyout    = 1'b1;
   assign hresp        = 1'b0;
   assign cmd.go       = go_q;
   assign cmd.op       = ctrl_q[1:0];
   assign cmd.lanesN   = ctrl_q[5:4];
   assign cmd.addr     = addr_q;
   assign cmd.wdata    = wdat_q;
   assign cmd.sleepReq = sleep_q;

endmodule : apsb_ahb_regs

//--- logic/apsb_ctrl.sv
// Host-side controller for the async/page pseudo-static memory bus
// Assumes a 250 MHz sys_clk, pins sampled synchronously, AHB-Lite software
//
// Function
// - Address lines carry word address, or config value during config load.
// - Read: select, output enable, byte strobes low, write strobe high; here the byte strobes follow the REG_CTRL lanes field.
// - Controller keeps chip select high through initialization.
// - Page: low four bits pick word, upper address bits held.
// - Page read starts with random read, then fast low-bit changes.
// - Config load is a write right after sleep falls.
//
// Implementation choices: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module apsb_ctrl #(
   parameter int INIT_CYCLES  = apsb_pkg::INIT_CYC,
   parameter int SLEEP_CYCLES = apsb_pkg::SLEEP_CYC
) (
   input  wire logic                           sys_clk,
   input  wire logic                           rst_n,
   input  wire logic                           hsel,
   input  wire logic [31:0]                    haddr,
   input  wire logic [1:0]                     htrans,
   input  wire logic                           hwrite,
   input  wire logic [2:0]                     hsize,
   input  wire logic [31:0]                    hwdata,
   input  wire logic                           hready,
   output logic      [31:0]                    hrdata,
   output logic                                hreadyout,
   output logic                                hresp,
   output logic      [apsb_pkg::ADDR_W-1:0]    memAddr,
   output logic                                chipSelect_n,
   output logic                                outputEnable_n,
   output logic                                writeStrobe_n,
   output logic                                lowByte_n,
   output logic                                highByte_n,
   output logic                                sleep_n,
   input  wire logic [apsb_pkg::DATA_W-1:0]    dataIn,
   output logic      [apsb_pkg::DATA_W-1:0]    dataOut,
   output logic      [1:0]                     dataOe_n
);
   import apsb_pkg::*;

   apsb_cmd_if cmd ();

   // ---------------------------------------------------------------
   // Register slave
   // ---------------------------------------------------------------
   apsb_ahb_regs uRegs (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .hsel      (hsel),
      .haddr     (haddr),
      .htrans    (htrans),
      .hwrite    (hwrite),
      .hsize     (hsize),
      .hwdata    (hwdata),
      .hready    (hready),
      .hrdata    (hrdata),
      .hreadyout (hreadyout),
      .hresp     (hresp),
      .cmd       (cmd)
   );

   // ---------------------------------------------------------------
   // Pin sequencer
   // ---------------------------------------------------------------
   apsb_state_t          state_q, state_d;
   logic [15:0]          cnt_q, cnt_d;
   logic [ADDR_W-1:0]    addr_q, addr_d;
   logic                 cs_q, cs_d, oe_q, oe_d, we_q, we_d, zz_q, zz_d;
   logic [1:0]           lanes_q, lanes_d;
   logic [DATA_W-1:0]    wd_q, wd_d, rd_q, rd_d;
   logic                 drive_q, drive_d;
   logic                 done_q, done_d;
   logic                 page_q, page_d;        // Mirror of config bit 7
   logic                 deep_q, deep_d;        // Mirror of config bit 4 == 0
   logic                 pageOpen_q, pageOpen_d;
   logic [ADDR_W-1:0]    pageBase_q, pageBase_d;
   logic                 ready_q, ready_d;

   // Same page test for page reads
   function automatic logic samePage(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] b);
      samePage = (a[ADDR_W-1:PAGE_LSB_W] == b[ADDR_W-1:PAGE_LSB_W]);
   endfunction : samePage

   // Next-state logic for every pin and status
   always_comb begin
      state_d    = state_q;
      cnt_d      = (cnt_q != 16'h0000) ? cnt_q - 16'h0001 : cnt_q;
      addr_d     = addr_q;
      cs_d       = cs_q;
      oe_d       = oe_q;
      we_d       = we_q;
      zz_d       = zz_q;
      lanes_d    = lanes_q;
      wd_d       = wd_q;
      rd_d       = rd_q;
      drive_d    = drive_q;
      done_d     = 1'b0;
      page_d     = page_q;
      deep_d     = deep_q;
      pageOpen_d = pageOpen_q;
      pageBase_d = pageBase_q;
      ready_d    = ready_q;
      case (state_q)
         APSB_S_INIT: begin
            cs_d = 1'b1;
            if (cnt_q == 16'h0000) begin
               ready_d = 1'b1;
               state_d = APSB_S_IDLE;
            end
         end
         APSB_S_IDLE: begin
            oe_d    = 1'b1;
            we_d    = 1'b1;
            drive_d = 1'b0;
            if (cmd.sleepReq) begin
               cs_d       = 1'b1;
               zz_d       = 1'b0;
               pageOpen_d = 1'b0;
               ready_d    = 1'b0;
               state_d    = APSB_S_SLEEP;
            end else if (cmd.go) begin
               addr_d  = cmd.addr;
               lanes_d = cmd.lanesN;
               case (cmd.op)
                  APSB_OP_READ: begin
                     cs_d    = 1'b0;
                     oe_d    = 1'b0;
                     we_d    = 1'b1;
                     // Page hit only with page mode enabled
                     if (page_q && pageOpen_q && samePage(cmd.addr, pageBase_q))
                        cnt_d = 16'(PAGE_CYC);
                     else
                        cnt_d = 16'(ACC_CYC);
                     pageOpen_d = page_q;
                     pageBase_d = cmd.addr;
                     state_d = APSB_S_RD;
                  end
                  APSB_OP_WRITE: begin
                     cs_d       = 1'b0;
                     we_d       = 1'b0;
                     wd_d       = cmd.wdata;
                     drive_d    = 1'b1;
                     cnt_d      = 16'(WP_CYC);
                     pageOpen_d = 1'b0;
                     state_d    = APSB_S_WR;
                  end
                  APSB_OP_CFG: begin
                     cs_d       = 1'b1;
                     zz_d       = 1'b0;
                     pageOpen_d = 1'b0;
                     cnt_d      = 16'h0001;
                     state_d    = APSB_S_CFGZ;
                  end
                  default: done_d = 1'b1;
               endcase
            end
         end
         APSB_S_RD: begin
            if (cnt_q == 16'h0000) begin
               rd_d   = dataIn;
               done_d = 1'b1;
               // Hold select low while page stays open; else release
               cs_d    = page_q ? 1'b0 : 1'b1;
               oe_d    = 1'b1;
               if (!page_q)
                  pageOpen_d = 1'b0;
               state_d = APSB_S_IDLE;
            end
         end
         APSB_S_WR: begin
            if (cnt_q == 16'h0000) begin
               we_d    = 1'b1;
               state_d = APSB_S_WREND;
            end
         end
         APSB_S_WREND: begin
            cs_d    = 1'b1;
            drive_d = 1'b0;
            done_d  = 1'b1;
            state_d = APSB_S_IDLE;
         end
         APSB_S_CFGZ: begin
            if (cnt_q == 16'h0000) begin
               cs_d    = 1'b0;
               we_d    = 1'b0;
               lanes_d = 2'b11;
               cnt_d   = 16'(WP_CYC);
               state_d = APSB_S_CFGW;
            end
         end
         APSB_S_CFGW: begin
            if (cnt_q == 16'h0000) begin
               we_d    = 1'b1;
               page_d  = addr_q[CFG_PAGE_B];
               deep_d  = !addr_q[CFG_SLEEP_B];
               state_d = APSB_S_CFGEND;
            end
         end
         APSB_S_CFGEND: begin
            cs_d    = 1'b1;
            zz_d    = 1'b1;
            done_d  = 1'b1;
            state_d = APSB_S_IDLE;
         end
         APSB_S_SLEEP: begin
            cs_d = 1'b1;
            if (!cmd.sleepReq) begin
               zz_d = 1'b1;
               if (deep_q) begin
                  cnt_d   = 16'(INIT_CYCLES);
                  state_d = APSB_S_INIT;
               end else begin
                  ready_d = 1'b1;
                  state_d = APSB_S_IDLE;
               end
            end
         end
         default: state_d = APSB_S_INIT;
      endcase
   end

   // Register the sequencer
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q    <= APSB_S_INIT;
         cnt_q      <= 16'(INIT_CYCLES);
         addr_q     <= '0;
         cs_q       <= 1'b1;
         oe_q       <= 1'b1;
         we_q       <= 1'b1;
         zz_q       <= 1'b1;
         lanes_q    <= 2'b11;
         wd_q       <= '0;
         rd_q       <= '0;
         drive_q    <= 1'b0;
         done_q     <= 1'b0;
         page_q     <= CFG_RESET[CFG_PAGE_B];
         deep_q     <= !CFG_RESET[CFG_SLEEP_B];
         pageOpen_q <= 1'b0;
         pageBase_q <= '0;
         ready_q    <= 1'b0;
      end else begin
         state_q    <= state_d;
         cnt_q      <= cnt_d;
         addr_q     <= addr_d;
         cs_q       <= cs_d;
         oe_q       <= oe_d;
         we_q       <= we_d;
         zz_q       <= zz_d;
         lanes_q    <= lanes_d;
         wd_q       <= wd_d;
         rd_q       <= rd_d;
         drive_q    <= drive_d;
         done_q     <= done_d;
         page_q     <= page_d;
         deep_q     <= deep_d;
         pageOpen_q <= pageOpen_d;
         pageBase_q <= pageBase_d;
         ready_q    <= ready_d;
      end
   end

   // Pins and status
   assign memAddr        = addr_q;
   assign chipSelect_n   = cs_q;
   assign outputEnable_n = oe_q;
   assign writeStrobe_n  = we_q;
   assign lowByte_n      = lanes_q[0];
   assign highByte_n     = lanes_q[1];
   assign sleep_n        = zz_q;
   assign dataOut        = wd_q;
   assign dataOe_n       = {!(drive_q && !lanes_q[1]), !(drive_q && !lanes_q[0])};
   assign cmd.done       = done_q;
   assign cmd.rdata      = rd_q;
   assign cmd.busy       = (state_q != APSB_S_IDLE) && (state_q != APSB_S_SLEEP);
   assign cmd.ready      = ready_q;
   assign cmd.pageOn     = page_q;
   assign cmd.asleep     = (state_q == APSB_S_SLEEP);

endmodule : apsb_ctrl

//--- tb/apsb_psram_model.sv
// Behavioural model of the pseudo-static memory device at the far side
// Assumes the bench resolves the shared data lanes into dataIn
`timescale 1ns/1ps
module apsb_psram_model #(
   parameter int INIT_NS = 200,
   parameter int ACC_NS  = 60,
   parameter int PG_NS   = 16
) (
   input  wire logic [21:0] memAddr,
   input  wire logic        chipSelect_n,
   input  wire logic        outputEnable_n,
   input  wire logic        writeStrobe_n,
   input  wire logic        lowByte_n,
   input  wire logic        highByte_n,
   input  wire logic        sleep_n,
   input  wire logic [15:0] dataIn,
   output logic      [15:0] devData,
   output logic      [1:0]  devOe_n
);
   logic [15:0] mem [logic [21:0]];
   logic [21:0] cfg = 22'h000070;
   logic [17:0] pageA;
   logic [1:0]  lanes;
   logic        arm, open = 1'b0, loaded;
   realtime     readyT = INIT_NS;
   realtime     chgT = 0;
   // New address or strobe restarts the access time
   always @(memAddr or chipSelect_n or outputEnable_n) chgT = $realtime;
   // Pins polled between clock edges; inverted data until access time
   initial begin
      #0.5;
      forever begin
         lanes = {highByte_n, lowByte_n};
         arm = !chipSelect_n && !writeStrobe_n && $realtime >= readyT;
         if (chipSelect_n) open = 1'b0;
         devOe_n = lanes | {2{!(!chipSelect_n && sleep_n && $realtime >= readyT
            && writeStrobe_n && !outputEnable_n)}};
         devData = mem.exists(memAddr) ? mem[memAddr] : 16'h0;
         if ($realtime - chgT < ((open && cfg[7] && memAddr[21:4] == pageA) ? PG_NS : ACC_NS))
            devData = ~devData;
         else if (devOe_n != 2'b11) begin
            open = 1'b1;
            pageA = memAddr[21:4];
         end
         #1;
      end
   end
   // First rising strobe takes the word or the configuration
   always @(posedge writeStrobe_n or posedge chipSelect_n or posedge lowByte_n
            or posedge highByte_n) begin
      if (arm && !sleep_n) begin
         cfg = memAddr;
         loaded = 1'b1;
      end else if (arm && sleep_n) begin
         if (!lanes[0]) mem[memAddr][7:0] = dataIn[7:0];
         if (!lanes[1]) mem[memAddr][15:8] = dataIn[15:8];
      end
      arm = 1'b0;
   end
   // Sleep pin: deep mode loses data and needs a fresh start
   always @(negedge sleep_n) loaded = 1'b0;
   always @(posedge sleep_n)
      if (!loaded && !cfg[4]) begin
         mem.delete();
         readyT = $realtime + INIT_NS;
      end
endmodule : apsb_psram_model

//--- tb/apsb_ctrl_chk.sv
// Checker on the pin side of the memory bus controller
// Assumes a bind onto apsb_ctrl; one clock, asynchronous active-low reset
`timescale 1ns/1ps
module apsb_ctrl_chk #(
   parameter int INIT_CYCLES = 50
) (
   input wire logic        sys_clk,
   input wire logic        rst_n,
   input wire logic [21:0] memAddr,
   input wire logic        chipSelect_n,
   input wire logic        outputEnable_n,
   input wire logic        writeStrobe_n,
   input wire logic        lowByte_n,
   input wire logic        highByte_n,
   input wire logic        sleep_n,
   input wire logic [15:0] dataOut,
   input wire logic [1:0]  dataOe_n
);
   int cnt_q, cnt_d;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   // Cycles since reset release, saturating
   always_comb cnt_d = (cnt_q < INIT_CYCLES) ? cnt_q + 1 : cnt_q;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) cnt_q <= 0;
      else cnt_q <= cnt_d;
   end
   chk_init_quiet: assert property (cnt_q < INIT_CYCLES |->
      chipSelect_n && sleep_n) else $error("select in power-up wait");
   chk_read_pins: assert property (!outputEnable_n |->
      !chipSelect_n && writeStrobe_n && sleep_n) else $error("bad pins in read");
   chk_read_bus: assert property (!outputEnable_n |-> dataOe_n == 2'b11)
      else $error("bus driven in read");
   chk_wr_lanes: assert property (!writeStrobe_n && !$past(writeStrobe_n) |->
      dataOe_n == {highByte_n, lowByte_n} && $stable(dataOut) && $stable(memAddr))
      else $error("write lanes or data wrong");
   chk_wr_release: assert property ($rose(writeStrobe_n) |->
      !chipSelect_n && dataOe_n == $past(dataOe_n) && $stable(dataOut))
      else $error("data gone at strobe rise");
   chk_wr_width: assert property ($fell(writeStrobe_n) |->
      !writeStrobe_n[*8] ##[1:16] writeStrobe_n) else $error("write width wrong");
   chk_cfg_load: assert property (!writeStrobe_n && !sleep_n |->
      lowByte_n && highByte_n && !chipSelect_n) else $error("bad config load");
   chk_zz_fall: assert property ($fell(sleep_n) |->
      chipSelect_n ##1 chipSelect_n) else $error("sleep pin while selected");
   chk_read_hold: assert property ($fell(outputEnable_n) |->
      !outputEnable_n[*5] ##[1:20] outputEnable_n) else $error("read length wrong");
   cov_read: cover property ($fell(outputEnable_n));
   cov_low_wr: cover property (!writeStrobe_n && !lowByte_n && highByte_n);
   cov_cfg: cover property (!writeStrobe_n && !sleep_n);
endmodule : apsb_ctrl_chk

//--- tb/tb_top.sv
// Testbench for the async/page memory bus controller
// Assumes the device model and the checker are compiled before it
`timescale 1ns/1ps
module tb_top;
   import apsb_pkg::*;
   localparam int INIT_N = 50;
   logic        sys_clk, rst_n, hsel, hwrite, hready, hreadyout, hresp, sleep_n;
   logic        chipSelect_n, outputEnable_n, writeStrobe_n, lowByte_n, highByte_n;
   logic [31:0] haddr, hwdata, hrdata;
   logic [21:0] memAddr;
   logic [15:0] dataIn, dataOut, devData;
   logic [15:0] junk = 16'h2c4e;
   logic [2:0]  hsize;
   logic [1:0]  htrans, dataOe_n, devOe_n;
   int          bad_count, check_count;
   apsb_ctrl #(.INIT_CYCLES(INIT_N)) i_apsb_ctrl (.*);
   apsb_psram_model #(.INIT_NS(INIT_N * 4)) i_apsb_psram_model (.*);
   assign hready = hreadyout;
   // Each lane from its driver, else a pattern changing every cycle
   always_comb
      for (int i = 0; i < 2; i++)
         dataIn[i*8+:8] = !dataOe_n[i] ? dataOut[i*8+:8]
                        : !devOe_n[i] ? devData[i*8+:8] : junk[i*8+:8];
   always @(posedge sys_clk) junk <= ~junk + 16'h1357;
   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end
   task automatic check(input logic [31:0] got, exp, mask);
      check_count++;
      if ((got & mask) !== (exp & mask)) begin
         bad_count++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask : check
   task automatic summarize();
      $display("comparisons %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : summarize
   task automatic give_up();
      bad_count++;
      summarize();
   endtask : give_up
   task automatic step();
      int n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (hready !== 1'b1 && n < 20);
      if (n >= 20) give_up();
   endtask : step
   // One word transfer: address phase, then data phase
   task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'b10;
      hwrite <= w;
      step();
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      step();
      r = hrdata;
   endtask : ahb
   task automatic wait_stat(input int b, input logic v);
      logic [31:0] s;
      int n = 0;
      do begin
         ahb(1'b0, REG_STATUS, 32'h0, s);
         n++;
      end while (s[b] !== v && n < 200);
      if (n >= 200) give_up();
   endtask : wait_stat
   // Load address and data, start one operation, wait until idle
   task automatic cmd(input apsb_op_t op, input logic [1:0] ln, input logic [21:0] a,
                      input logic [15:0] d);
      logic [31:0] r;
      ahb(1'b1, REG_ADDR, {10'h0, a}, r);
      ahb(1'b1, REG_WDATA, {16'h0, d}, r);
      ahb(1'b1, REG_CTRL, {26'h0, ln, 2'b01, op}, r);
      repeat (3) @(posedge sys_clk);
      wait_stat(0, 1'b0);
   endtask : cmd
   task automatic mem_rd(input logic [1:0] ln, input logic [21:0] a, input logic [15:0] e, m);
      logic [31:0] r;
      cmd(APSB_OP_READ, ln, a, 16'h0);
      ahb(1'b0, REG_RDATA, 32'h0, r);
      check(r, {16'h0, e}, {16'h0, m});
   endtask : mem_rd
   task automatic t_power();
      logic [31:0] s;
      ahb(1'b0, REG_STATUS, 32'h0, s);
      check(s, 32'h0, 32'h6);
      ahb(1'b0, 8'h3c, 32'h0, s);
      check(s, 32'h0, 32'hffffffff);
      wait_stat(1, 1'b1);
      ahb(1'b0, REG_STATUS, 32'h0, s);
      check(s, 32'h2, 32'hf);
   endtask : t_power
   task automatic t_lanes();
      cmd(APSB_OP_WRITE, 2'b00, 22'h3ffff0, 16'hbeef);
      cmd(APSB_OP_WRITE, 2'b10, 22'h3ffff0, 16'h1234);
      cmd(APSB_OP_WRITE, 2'b11, 22'h3ffff0, 16'h5555);
      cmd(APSB_OP_NONE, 2'b00, 22'h3ffff0, 16'h6666);
      mem_rd(2'b00, 22'h3ffff0, 16'hbe34, 16'hffff);
      mem_rd(2'b01, 22'h3ffff0, 16'hbe00, 16'hff00);
      cmd(APSB_OP_WRITE, 2'b00, 22'h000001, 16'h0f0f);
      mem_rd(2'b00, 22'h000001, 16'h0f0f, 16'hffff);
   endtask : t_lanes
   task automatic t_page();
      logic [31:0] s;
      cmd(APSB_OP_WRITE, 2'b00, 22'h000020, 16'ha001);
      cmd(APSB_OP_WRITE, 2'b00, 22'h00002f, 16'ha00f);
      cmd(APSB_OP_WRITE, 2'b00, 22'h000030, 16'ha010);
      cmd(APSB_OP_CFG, 2'b11, 22'h000090, 16'h0);
      ahb(1'b0, REG_STATUS, 32'h0, s);
      check(s, 32'h4, 32'h4);
      mem_rd(2'b00, 22'h000020, 16'ha001, 16'hffff);
      mem_rd(2'b00, 22'h00002f, 16'ha00f, 16'hffff);
      mem_rd(2'b00, 22'h000030, 16'ha010, 16'hffff);
      cmd(APSB_OP_WRITE, 2'b00, 22'h000031, 16'hc0de);
      mem_rd(2'b00, 22'h000031, 16'hc0de, 16'hffff);
   endtask : t_page
   task automatic t_sleep();
      logic [31:0] s;
      ahb(1'b1, REG_SLEEP, 32'h1, s);
      wait_stat(3, 1'b1);
      ahb(1'b1, REG_SLEEP, 32'h0, s);
      wait_stat(1, 1'b1);
      mem_rd(2'b00, 22'h000031, 16'hc0de, 16'hffff);
      cmd(APSB_OP_CFG, 2'b11, 22'h000000, 16'h0);
      ahb(1'b1, REG_SLEEP, 32'h1, s);
      wait_stat(3, 1'b1);
      ahb(1'b1, REG_SLEEP, 32'h0, s);
      wait_stat(1, 1'b1);
      cmd(APSB_OP_WRITE, 2'b00, 22'h155555, 16'h7e57);
      mem_rd(2'b00, 22'h155555, 16'h7e57, 16'hffff);
   endtask : t_sleep
   initial begin
      {rst_n, hsel, hwrite} = 3'b000;
      haddr = 32'h0;
      hwdata = 32'h0;
      htrans = 2'b00;
      hsize = 3'b010;
      bad_count = 0;
      check_count = 0;
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'b1;
      t_power();
      t_lanes();
      t_page();
      t_sleep();
      summarize();
   end
endmodule : tb_top
bind apsb_ctrl apsb_ctrl_chk #(.INIT_CYCLES(INIT_CYCLES)) i_apsb_ctrl_chk (.*);
